// ---- logic/leak_consts.svh ----
// Constants for the leak mitigation status controller.
// Assumes a 10 MHz clock; times are held in their own unit.
`ifndef LEAK_CONSTS_SVH
`define LEAK_CONSTS_SVH
`define CLK_HZ 10000000
`define SLOW_HALF_S 2
`define DELAY_S 300
`define VERIFY_S 300
`define PRESS_WINDOW_S 5
`define FAULT_GAP_S 5
`define FAST_HALF_MS 250
`define CYC_PER_S (`CLK_HZ)
`define CYC_FAST_HALF ((`CLK_HZ / 1000) * `FAST_HALF_MS)
`define LFL_LIMIT_PCT 8'h19
`define FLASH_INT 3'h2
`define FLASH_COMM 3'h3
`define FLASH_SENS 3'h4
`endif

// ---- logic/leak_pkg.sv ----
// Types shared by the leak mitigation status controller.
// Assumes nothing of its surroundings.
package leak_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_ALARM = 3'h1,
    MODE_DELAY = 3'h2,
    MODE_VERIFY = 3'h3,
    MODE_FAULT = 3'h4
  } mode_t;
  typedef enum logic [1:0] {
    LED_SLOW = 2'h0,
    LED_FAST = 2'h1,
    LED_STEADY = 2'h2,
    LED_GROUP = 2'h3
  } led_pat_t;
endpackage : leak_pkg

// ---- logic/led_if.sv ----
// Pattern request from the mode controller to the LED pattern maker.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface led_if;
  leak_pkg::led_pat_t pattern;
  logic [2:0] flashes;
  logic tick_s;
  modport ctrl (output pattern, output flashes, output tick_s);
  modport gen (input pattern, input flashes, input tick_s);
endinterface : led_if
`default_nettype wire

// ---- logic/led_pattern.sv ----
// LED pattern maker: slow, fast, steady and flash-group patterns.
// Assumes a one-second tick from the controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "leak_consts.svh"
module led_pattern #(
  parameter int FAST_HALF = `CYC_FAST_HALF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Pattern request
  led_if.gen req,
  // Lamp
  output logic led
);
  localparam logic [23:0] FAST_MAX = 24'(FAST_HALF - 1);
  logic [23:0] fcnt_reg, fcnt_next;
  logic ftick;
  logic [1:0] scnt_reg, scnt_next;
  logic [3:0] step_reg, step_next;
  logic [2:0] gap_reg, gap_next;
  logic fph_reg, fph_next;
  logic led_reg, led_next;
  leak_pkg::led_pat_t last_reg;

  assign ftick = (fcnt_reg == FAST_MAX);
  assign led = led_reg;

  always_comb begin
    fcnt_next = ftick ? 24'h0 : fcnt_reg + 24'h1;
    fph_next = ftick ? ~fph_reg : fph_reg;
    scnt_next = scnt_reg;
    step_next = step_reg;
    gap_next = gap_reg;
    if (req.tick_s) begin
      scnt_next = (scnt_reg == 2'(2 * `SLOW_HALF_S - 1)) ? 2'h0
                  : scnt_reg + 2'h1;
    end
    // Flash group: 2n fast half-periods, then a dark gap in seconds
    if (step_reg < {req.flashes, 1'b0}) begin
      if (ftick) step_next = step_reg + 4'h1;
    end else if (req.tick_s) begin
      if (gap_reg == 3'(`FAULT_GAP_S - 1)) begin
        gap_next = 3'h0;
        step_next = 4'h0;
      end else begin
        gap_next = gap_reg + 3'h1;
      end
    end
    if (req.pattern != last_reg) begin
      step_next = 4'h0;
      gap_next = 3'h0;
      scnt_next = 2'h0;
    end
    unique case (req.pattern)
      leak_pkg::LED_SLOW: led_next = ~scnt_reg[1];
      leak_pkg::LED_FAST: led_next = ~fph_reg;
      leak_pkg::LED_STEADY: led_next = 1'b1;
      leak_pkg::LED_GROUP: led_next = (step_reg < {req.flashes, 1'b0})
                                      && !step_reg[0];
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fcnt_reg <= 24'h0;
      fph_reg <= 1'b0;
      scnt_reg <= 2'h0;
      step_reg <= 4'h0;
      gap_reg <= 3'h0;
      led_reg <= 1'b0;
      last_reg <= leak_pkg::LED_SLOW;
    end else begin
      fcnt_reg <= fcnt_next;
      fph_reg <= fph_next;
      scnt_reg <= scnt_next;
      step_reg <= step_next;
      gap_reg <= gap_next;
      led_reg <= led_next;
      last_reg <= req.pattern;
    end
  end

  property p_steady_lit;
    @(posedge clock) disable iff (srst)
      (req.pattern == leak_pkg::LED_STEADY) [*2] |-> led;
  endproperty
  a_steady_lit: assert property (p_steady_lit)
    else $error("LED not steady in delay mode");
endmodule : led_pattern
`default_nettype wire

// ---- logic/leak_mitigation_status_controller.sv ----
// Mode controller for a refrigerant leak detection board.
// Assumes sensor and button levels from outside the clock domain.
// What this block does
// - No alarm or fault: normal mode, LED two seconds on, two off.
// - Sensor over threshold: leak alarm mode, fast LED blink.
// - Alarm cleared: delay mode, mitigation kept five minutes.
// - Delay mode holds the LED steadily lit.
// - Any cleared fault also passes through the five-minute delay.
// - Two button presses within five seconds start verification.
// - Verification acts as a simulated alarm, fast blink, five minutes max.
// - Verification expiry returns to normal without button input.
// - One press during verification ends the test early.
// - Internal fault: two flashes then five seconds dark, repeated.
// - Sensor link lost: three flashes then five seconds dark.
// - Sensor reports fault: four flashes then five seconds dark.
// - Relay failure or sensor line short raises internal fault.
// - Mitigation stops conditioning and runs the indoor blower.
// - New leak during or after delay restarts mitigation and delay.
// - Leak means concentration above 25 percent of lower limit.
`timescale 1ns/1ps
`default_nettype none
`include "leak_consts.svh"
module leak_mitigation_status_controller #(
  parameter int CYC_PER_S = `CYC_PER_S,
  parameter int FAST_HALF = `CYC_FAST_HALF,
  parameter int DELAY_S = `DELAY_S,
  parameter int VERIFY_S = `VERIFY_S,
  parameter logic [7:0] LFL_LIMIT = `LFL_LIMIT_PCT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Sensor side
  input wire logic [7:0] concentration_pct,
  input wire logic sensor_comm_ok,
  input wire logic sensor_fault,
  // Board health
  input wire logic relay_fail,
  input wire logic comm_line_short,
  // Service button, high while pressed
  input wire logic button,
  // Outputs
  output logic status_led,
  output logic conditioning_enable,
  output logic blower_on,
  output logic [2:0] mode
);
  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [7:0] conc_s1, conc_s2;
  logic [4:0] lvl_s1, lvl_s2;
  logic btn_prev;
  always_ff @(posedge clock) begin
    if (srst) begin
      conc_s1 <= 8'h0;
      conc_s2 <= 8'h0;
      lvl_s1 <= 5'h1;
      lvl_s2 <= 5'h1;
      btn_prev <= 1'b0;
    end else begin
      conc_s1 <= concentration_pct;
      conc_s2 <= conc_s1;
      lvl_s1 <= {button, relay_fail, comm_line_short, sensor_fault,
                 sensor_comm_ok};
      lvl_s2 <= lvl_s1;
      btn_prev <= lvl_s2[4];
    end
  end
  // Bus words may tear across the crossing; one sample is wrong
  // at worst, which a slow gas level tolerates.
  logic leak, f_int, f_comm, f_sens, press, any_fault;
  assign leak = lvl_s2[0] && (conc_s2 > LFL_LIMIT);
  assign f_int = lvl_s2[3] | lvl_s2[2];
  assign f_comm = !lvl_s2[0];
  assign f_sens = lvl_s2[0] && lvl_s2[1];
  assign any_fault = f_int | f_comm | f_sens;
  assign press = lvl_s2[4] && !btn_prev;

  ////////////////////////////////////////////////////////////////////
  // One-second timebase
  localparam logic [23:0] SEC_MAX = 24'(CYC_PER_S - 1);
  logic [23:0] pre_reg, pre_next;
  logic tick_s;
  assign tick_s = (pre_reg == SEC_MAX);
  always_comb begin
    pre_next = tick_s ? 24'h0 : pre_reg + 24'h1;
  end
  always_ff @(posedge clock) begin
    if (srst) pre_reg <= 24'h0;
    else pre_reg <= pre_next;
  end

  ////////////////////////////////////////////////////////////////////
  // Mode machine
  leak_pkg::mode_t mode_reg, mode_next;
  logic [8:0] secs_reg, secs_next;
  logic [2:0] win_reg, win_next;
  logic armed_reg, armed_next;
  logic [2:0] flashes;
  leak_pkg::led_pat_t pattern;

  always_comb begin
    mode_next = mode_reg;
    secs_next = tick_s ? secs_reg + 9'h1 : secs_reg;
    win_next = (armed_reg && tick_s) ? win_reg + 3'h1 : win_reg;
    armed_next = armed_reg;
    if (armed_reg && win_reg == 3'(`PRESS_WINDOW_S)) armed_next = 1'b0;
    unique case (mode_reg)
      leak_pkg::MODE_NORMAL: begin
        if (press) begin
          if (armed_reg) begin
            mode_next = leak_pkg::MODE_VERIFY;
            armed_next = 1'b0;
            secs_next = 9'h0;
          end else begin
            armed_next = 1'b1;
            win_next = 3'h0;
          end
        end
      end
      leak_pkg::MODE_VERIFY: begin
        if (press || secs_reg == 9'(VERIFY_S)) begin
          mode_next = leak_pkg::MODE_NORMAL;
        end
      end
      leak_pkg::MODE_ALARM, leak_pkg::MODE_FAULT: begin
        if (!leak && !any_fault) begin
          mode_next = leak_pkg::MODE_DELAY;
          secs_next = 9'h0;
        end
      end
      leak_pkg::MODE_DELAY: begin
        if (secs_reg == 9'(DELAY_S)) mode_next = leak_pkg::MODE_NORMAL;
      end
      default: mode_next = leak_pkg::MODE_NORMAL;
    endcase
    if (any_fault) mode_next = leak_pkg::MODE_FAULT;
    else if (leak) mode_next = leak_pkg::MODE_ALARM;
    if (mode_next != leak_pkg::MODE_NORMAL) armed_next = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= leak_pkg::MODE_NORMAL;
      secs_reg <= 9'h0;
      win_reg <= 3'h0;
      armed_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      secs_reg <= secs_next;
      win_reg <= win_next;
      armed_reg <= armed_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // LED selection and outputs
  always_comb begin
    flashes = 3'h0;
    if (f_int) flashes = `FLASH_INT;
    else if (f_comm) flashes = `FLASH_COMM;
    else if (f_sens) flashes = `FLASH_SENS;
    unique case (mode_reg)
      leak_pkg::MODE_FAULT: pattern = leak_pkg::LED_GROUP;
      leak_pkg::MODE_ALARM, leak_pkg::MODE_VERIFY: pattern = leak_pkg::LED_FAST;
      leak_pkg::MODE_DELAY: pattern = leak_pkg::LED_STEADY;
      default: pattern = leak_pkg::LED_SLOW;
    endcase
  end

  led_if lif();
  assign lif.pattern = pattern;
  assign lif.flashes = flashes;
  assign lif.tick_s = tick_s;

  led_pattern #(.FAST_HALF(FAST_HALF)) u_led (
    .clock(clock),
    .srst(srst),
    .req(lif.gen),
    .led(status_led)
  );

  logic mit_reg;
  always_ff @(posedge clock) begin
    if (srst) mit_reg <= 1'b0;
    else mit_reg <= (mode_next != leak_pkg::MODE_NORMAL);
  end
  assign conditioning_enable = !mit_reg;
  assign blower_on = mit_reg;
  assign mode = mode_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_fault_first;
    @(posedge clock) disable iff (srst)
      any_fault |=> mode_reg == leak_pkg::MODE_FAULT;
  endproperty
  a_fault_first: assert property (p_fault_first)
    else $error("Fault did not take priority");
  property p_leak_alarm;
    @(posedge clock) disable iff (srst)
      (leak && !any_fault) |=> mode_reg == leak_pkg::MODE_ALARM;
  endproperty
  a_leak_alarm: assert property (p_leak_alarm)
    else $error("Leak did not raise alarm");
  property p_clear_delay;
    @(posedge clock) disable iff (srst)
      (mode_reg inside {leak_pkg::MODE_ALARM, leak_pkg::MODE_FAULT}
       && !leak && !any_fault) |=> mode_reg == leak_pkg::MODE_DELAY;
  endproperty
  a_clear_delay: assert property (p_clear_delay)
    else $error("Clear did not enter delay");
  property p_mitigate;
    @(posedge clock) disable iff (srst)
      mode_reg != leak_pkg::MODE_NORMAL |-> blower_on && !conditioning_enable;
  endproperty
  a_mitigate: assert property (p_mitigate)
    else $error("Mitigation outputs wrong");
  property p_delay_end;
    @(posedge clock) disable iff (srst)
      (mode_reg == leak_pkg::MODE_DELAY && secs_reg == 9'(DELAY_S)
       && !leak && !any_fault) |=> mode_reg == leak_pkg::MODE_NORMAL;
  endproperty
  a_delay_end: assert property (p_delay_end)
    else $error("Delay did not end on time");
  property p_verify_stop;
    @(posedge clock) disable iff (srst)
      (mode_reg == leak_pkg::MODE_VERIFY && press && !leak && !any_fault)
      |=> mode_reg == leak_pkg::MODE_NORMAL;
  endproperty
  a_verify_stop: assert property (p_verify_stop)
    else $error("Press did not stop test");
  property p_verify_len;
    @(posedge clock) disable iff (srst)
      mode_reg == leak_pkg::MODE_VERIFY |-> secs_reg <= 9'(VERIFY_S);
  endproperty
  a_verify_len: assert property (p_verify_len)
    else $error("Test overran its time");
  property p_enter_verify;
    @(posedge clock) disable iff (srst)
      (mode_reg == leak_pkg::MODE_NORMAL && armed_reg && press && !leak
       && !any_fault) |=> mode_reg == leak_pkg::MODE_VERIFY;
  endproperty
  a_enter_verify: assert property (p_enter_verify)
    else $error("Double press did not start test");
endmodule : leak_mitigation_status_controller
`default_nettype wire

// ---- test/sensor_button_model.sv ----
// Far side model: refrigerant sensor link, board health lines, button.
// Assumes the bench changes its commands just after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module sensor_button_model (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic [7:0] level,
  input wire logic [3:0] health,
  input wire logic press_level,
  // Sensor side
  output logic [7:0] concentration_pct,
  output logic sensor_comm_ok,
  output logic sensor_fault,
  // Board health
  output logic relay_fail,
  output logic comm_line_short,
  // Service button
  output logic button
);
  logic [7:0] noise_reg = 8'h5a;
  always @(negedge clock) noise_reg <= noise_reg + 8'h3b;
  // Health bits: relay, line short, link lost, sensor fault
  assign relay_fail = health[3];
  assign comm_line_short = health[2];
  assign sensor_comm_ok = !health[1];
  assign sensor_fault = health[0];
  // Lost link: reading is garbage, never the last good value
  assign concentration_pct = health[1] ? noise_reg : level;
  assign button = press_level;
endmodule : sensor_button_model
`default_nettype wire

// ---- test/tb_leak_mitigation_status_controller.sv ----
// Self-checking bench for the leak mitigation status controller.
// Assumes shortened second, blink and delay counts set below.
`timescale 1ns/1ps
`default_nettype none
module tb_leak_mitigation_status_controller;
  localparam int CPS = 10;
  localparam int FAST = 2;
  localparam int DLY = 3;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] level_cmd = 8'h00;
  logic [3:0] health_cmd = 4'h0;
  logic btn_cmd = 1'b0;
  wire logic [7:0] conc;
  wire logic comm_ok, s_fault, r_fail, l_short, button;
  logic status_led, conditioning_enable, blower_on;
  logic [2:0] mode;
  int num_errors = 0;
  int tests_run = 0;
  logic [2:0] exp_q[$];
  logic [2:0] last_mode = 3'h0;
  logic blw_due = 1'b0;
  logic [3:0] cause [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h9, 4'h3};
  int want [6] = '{2, 2, 3, 4, 2, 3};
  always #50 clock = ~clock;
  sensor_button_model sensor_button_model_inst (.clock(clock),
    .level(level_cmd), .health(health_cmd), .press_level(btn_cmd),
    .concentration_pct(conc), .sensor_comm_ok(comm_ok),
    .sensor_fault(s_fault), .relay_fail(r_fail),
    .comm_line_short(l_short), .button(button));
  leak_mitigation_status_controller #(.CYC_PER_S(CPS), .FAST_HALF(FAST),
    .DELAY_S(DLY), .VERIFY_S(DLY)) leak_mitigation_status_controller_inst (
    .clock(clock), .srst(srst), .concentration_pct(conc),
    .sensor_comm_ok(comm_ok), .sensor_fault(s_fault), .relay_fail(r_fail),
    .comm_line_short(l_short), .button(button), .status_led(status_led),
    .conditioning_enable(conditioning_enable), .blower_on(blower_on),
    .mode(mode));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // Wait for a mode noted before its stimulus; the monitor compares
  task automatic expect_mode(input logic [2:0] want_m, output int t);
    t = 0;
    while (mode !== want_m && t < 500) begin
      @(negedge clock);
      t++;
    end
    if (t >= 500) check(1'b0, "mode not reached");
  endtask : expect_mode
  // One whole press and release, each held for hold cycles
  task automatic press(input int hold);
    btn_cmd = 1'b1;
    repeat (hold) @(negedge clock);
    btn_cmd = 1'b0;
    repeat (hold) @(negedge clock);
  endtask : press
  task automatic high_run(output int n);
    int k;
    k = 0;
    n = 0;
    // Skip a run that a pattern switch may have cut short
    repeat (2) @(negedge clock);
    while (status_led === 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    while (status_led !== 1'b1 && k < 800) begin
      @(negedge clock);
      k++;
    end
    while (status_led === 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
  endtask : high_run
  // Pulses between two long dark gaps
  task automatic flashes(output int cnt);
    int dark;
    int k;
    cnt = 0;
    dark = 0;
    k = 0;
    while (dark < 30 && k < 600) begin
      @(negedge clock);
      k++;
      dark = (status_led === 1'b1) ? 0 : dark + 1;
    end
    dark = 1;
    while (dark < 30 && k < 1200) begin
      @(negedge clock);
      k++;
      if (status_led === 1'b1 && dark > 0) cnt++;
      dark = (status_led === 1'b1) ? 0 : dark + 1;
    end
  endtask : flashes
  ////////////////////////////////////////////////////////////////////////
  // Output monitor: every mode change must match the oldest note
  always @(negedge clock) begin
    if (blw_due) begin
      check(blower_on === (last_mode != 3'h0) &&
        conditioning_enable === (last_mode == 3'h0), "mitigation");
    end
    blw_due <= 1'b0;
    if (srst) begin
      last_mode <= mode;
    end else if (mode !== last_mode) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected mode change");
      end else begin
        check(mode === exp_q.pop_front(), "mode");
      end
      last_mode <= mode;
      blw_due <= 1'b1;
    end
  end
  initial begin
    #(20000 * 100);
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    n = $urandom(85);
    repeat (20) @(negedge clock);
    srst = 1'b0;
    high_run(n);
    check(n == 2 * CPS, "slow blink");
    $display("test normal done");
    // Exactly 25 percent is not yet a leak
    level_cmd = 8'h19;
    repeat (60) @(negedge clock);
    exp_q.push_back(3'h1);
    level_cmd = 8'h1a + 8'($urandom % 230);
    expect_mode(3'h1, n);
    high_run(n);
    check(n == FAST, "fast blink");
    press(2);
    press(2);
    exp_q.push_back(3'h2);
    level_cmd = 8'h00;
    expect_mode(3'h2, n);
    repeat (3) @(negedge clock);
    repeat (12) begin
      @(negedge clock);
      check(status_led === 1'b1, "steady");
    end
    exp_q.push_back(3'h1);
    level_cmd = 8'h40;
    expect_mode(3'h1, n);
    exp_q.push_back(3'h2);
    exp_q.push_back(3'h0);
    level_cmd = 8'h00;
    expect_mode(3'h2, n);
    expect_mode(3'h0, n);
    check(n > (DLY - 1) * CPS && n <= DLY * CPS + 2, "delay");
    $display("test leak done");
    exp_q.push_back(3'h3);
    exp_q.push_back(3'h0);
    press(1 + $urandom % 3);
    press(2);
    expect_mode(3'h3, n);
    high_run(n);
    check(n == FAST, "test blink");
    expect_mode(3'h0, n);
    check(n > (DLY - 2) * CPS && n <= DLY * CPS + 2, "expiry");
    exp_q.push_back(3'h3);
    exp_q.push_back(3'h0);
    press(2);
    press(2);
    expect_mode(3'h3, n);
    press(2);
    expect_mode(3'h0, n);
    check(n < CPS, "early end");
    // Presses too far apart start nothing
    repeat (60) @(negedge clock);
    press(2);
    repeat (60) @(negedge clock);
    press(2);
    repeat (60) @(negedge clock);
    $display("test verify done");
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(3'h4);
      health_cmd = cause[i];
      expect_mode(3'h4, n);
      flashes(n);
      check(n == want[i], "flash count");
      exp_q.push_back(3'h2);
      exp_q.push_back(3'h0);
      health_cmd = 4'h0;
      expect_mode(3'h2, n);
      expect_mode(3'h0, n);
    end
    $display("test faults done");
    summarize();
  end
endmodule : tb_leak_mitigation_status_controller
`default_nettype wire
